// ---- hdl/prescale_counter.sv ----
// Watchdog base counter and the prescaler shared with Timer0
`timescale 1ns/10ps
`default_nettype none
module prescale_counter #(
  parameter int BASE_TICKS = wdt_pkg::WDT_BASE_TICKS_DEF
) (
  input wire logic   clk,
  input wire logic   rst_b,
  wdt_count_if.counter cnt
);
  import wdt_pkg::*;
  localparam int BW = $clog2(BASE_TICKS);

  if (BASE_TICKS < 2) begin : g_chk
    $error("BASE_TICKS must be at least 2");
  end

  logic [BW-1:0] base_cnt;
  logic [7:0]    shared_cnt;
  logic          base_tc;
  logic [7:0]    wdt_last;
  logic [7:0]    t0_last;

  assign base_tc  = cnt.enable && cnt.wdt_tick && (base_cnt == BW'(BASE_TICKS - 1));
  assign wdt_last = (8'h01 << cnt.ratio) - 8'h01;
  assign t0_last  = (8'h02 << cnt.ratio) - 8'h01;

  // ==========================================================
  // Base period, counted on the RC oscillator ticks
  always_ff @(posedge clk) begin
    if (!rst_b || cnt.clear || !cnt.enable) begin
      base_cnt <= '0;  // R7 R5
    end else if (cnt.wdt_tick) begin
      base_cnt <= base_tc ? '0 : base_cnt + BW'(1);  // R1 R22
    end
  end

  // ==========================================================
  // One counter, owned by either the watchdog or Timer0
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shared_cnt <= '0;
    end else if (cnt.assign_wdt) begin
      if (cnt.clear) begin
        shared_cnt <= '0;  // R8
      end else if (base_tc) begin
        shared_cnt <= (shared_cnt == wdt_last) ? '0 : shared_cnt + 8'h01;  // R6
      end
    end else if (cnt.tmr0_tick) begin
      shared_cnt <= (shared_cnt == t0_last) ? '0 : shared_cnt + 8'h01;  // R6
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt.expire   <= 1'b0;
      cnt.tmr0_inc <= 1'b0;
    end else begin
      cnt.expire   <= base_tc && !cnt.clear && (!cnt.assign_wdt || shared_cnt == wdt_last);
      cnt.tmr0_inc <= cnt.tmr0_tick && (cnt.assign_wdt || shared_cnt == t0_last);
    end
  end

  a_clear_zeroes: assert property (  // R7
    @(posedge clk) disable iff (!rst_b)
    cnt.clear |=> base_cnt == '0 && !cnt.expire)
    else $error("watchdog clear did not zero the count");
endmodule
`default_nettype wire

// ---- hdl/startup_delay.sv ----
// Oscillator start-up wait before execution resumes
`timescale 1ns/10ps
`default_nettype none
module startup_delay #(
  parameter int CYCLES = wdt_pkg::OST_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic abort,
  input  wire logic start,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_chk
    $error("CYCLES must be at least 1");
  end

  logic [CW-1:0] left;
  logic          busy;
  logic [CW-1:0] span;

  always_ff @(posedge clk) begin
    if (!rst_b || abort) begin
      busy <= 1'b0;
      left <= '0;
      done <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      left <= CW'(CYCLES - 1);
      done <= 1'b0;
    end else begin
      done <= busy && left == '0;  // R19
      busy <= busy && left != '0;
      left <= (left != '0) ? left - CW'(1) : left;
    end
  end

  // Span of the wait, seen only by the check below
  always_ff @(posedge clk) begin
    if (!rst_b || start) begin
      span <= '0;
    end else if (busy) begin
      span <= span + CW'(1);
    end
  end

  a_startup_span: assert property (  // R19
    @(posedge clk) disable iff (!rst_b)
    done && !$past(abort) |-> span == CW'(CYCLES))
    else $error("start-up wait has the wrong length");
endmodule
`default_nettype wire

// ---- hdl/watchdog_sleep_wakeup.sv ----
// Watchdog, sleep entry and wake-up control with an AXI4-Lite register port
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// [R1] Watchdog counts ticks of its own oscillator
// [R2] Expiry while running resets the device
// [R3] Expiry while asleep wakes and resumes
// [R4] Any expiry clears the timeout flag; one in the same cycle as a sleep leaves it set
// [R5] Cleared enable fuse stops the watchdog
// [R6] Shared prescaler, owner bit, three-bit ratio
// [R7] Clear or sleep zeroes count and postscaler
// [R8] Clear zeroes prescaler, keeps owner setting
// [R9] Sleep: clear watchdog, flags, oscillator off
// [R10] Pins hold their drive during sleep
// [R11] Reset pin resets; other wakes continue
// [R12] Powerdown flag set at power-up only
// [R13] Only clockless sources wake from sleep
// [R14] Next instruction prefetched during sleep
// [R15] Wake needs source enable, ignores global
// [R16] Run next instruction, then vector if enabled
// [R17] Pending enabled interrupt makes sleep a no-op
// [R18] Late interrupt: full sleep, then wake
// [R19] Crystal modes wait 1024 periods after wake
// [R20] Only return address saved on entry
// [R21] Software clears watchdog, checks flag after
// [R22] Base period is a parameter, scaled by ratio
module watchdog_sleep_wakeup #(
  parameter int         IRQ_COUNT       = 8,
  parameter logic [7:0] SLEEP_WAKE_MASK = 8'hFF,
  parameter int         WDT_BASE_TICKS  = wdt_pkg::WDT_BASE_TICKS_DEF
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_B,
  input  wire logic [11:0]          AWADDR,
  input  wire logic                 AWVALID,
  output logic                      AWREADY,
  input  wire logic [31:0]          WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output logic                      WREADY,
  output logic [1:0]                BRESP,
  output logic                      BVALID,
  input  wire logic                 BREADY,
  input  wire logic [11:0]          ARADDR,
  input  wire logic                 ARVALID,
  output logic                      ARREADY,
  output logic [31:0]               RDATA,
  output logic [1:0]                RRESP,
  output logic                      RVALID,
  input  wire logic                 RREADY,
  input  wire logic                 WDT_OSC_TICK,
  input  wire logic                 TMR0_CLK_TICK,
  output logic                      TMR0_INCREMENT,
  input  wire logic                 CLEAR_WATCHDOG_INSTR,
  input  wire logic                 SLEEP_INSTR,
  input  wire logic                 GLOBAL_IRQ_ENABLE,
  input  wire logic [IRQ_COUNT-1:0] IRQ_FLAGS,
  input  wire logic [IRQ_COUNT-1:0] IRQ_ENABLES,
  input  wire logic                 MASTER_CLEAR_PIN_B,
  output logic                      DEVICE_RESET,
  output logic                      WATCHDOG_RESET,
  output logic                      PREFETCH_NEXT,
  output logic                      CORE_HALT,
  output logic                      RESUME,
  output logic                      VECTOR_AFTER_NEXT,
  output logic [12:0]               VECTOR_ADDR,
  output logic                      IO_HOLD,
  output logic                      OSC_DRIVER_ON,
  output logic                      TIMEOUT_FLAG,
  output logic                      POWERDOWN_FLAG
);
  import wdt_pkg::*;

  if (IRQ_COUNT < 1 || IRQ_COUNT > 8) begin : g_chk
    $error("IRQ_COUNT must be 1 to 8");
  end

  typedef enum logic [1:0] {MODE_RUN, MODE_ASLEEP, MODE_STARTUP} mode_e;

  mode_e      mode;
  logic [7:0] config_word;
  logic [7:0] timer_prescale_option;
  logic       timeout_flag;
  logic       powerdown_flag;
  logic       master_clear_pin;
  logic       wdt_enabled;
  logic       crystal_mode;
  logic       irq_pending;
  logic       irq_wake;
  logic       sleep_exec;
  logic       sleep_nop;
  logic       wdt_reset_evt;
  logic       wdt_wake_evt;
  logic       wake;
  logic       start_delay;
  logic       delay_done;
  logic       next_resume;
  logic       wr_take;
  logic       rd_take;
  logic [7:0] wake_mask;

  wdt_count_if cnt_if ();

  // ==========================================================
  // Event decode
  assign master_clear_pin         = !MASTER_CLEAR_PIN_B;
  assign wdt_enabled  = config_word[CFG_WDT_EN_BIT];  // R5
  assign crystal_mode = config_word[CFG_OSC_LSB +: 2] != OSC_RC;  // R19
  assign wake_mask    = SLEEP_WAKE_MASK;
  assign irq_pending  = |(IRQ_FLAGS & IRQ_ENABLES);  // R15
  // Sources that need on-chip clocks stay masked while asleep
  assign irq_wake     = |(IRQ_FLAGS & IRQ_ENABLES & wake_mask[IRQ_COUNT-1:0]);  // R13
  assign sleep_exec   = SLEEP_INSTR && mode == MODE_RUN && !irq_pending && !master_clear_pin;
  assign sleep_nop    = SLEEP_INSTR && mode == MODE_RUN && irq_pending;  // R17
  assign wdt_reset_evt = cnt_if.expire && mode != MODE_ASLEEP;  // R2
  assign wdt_wake_evt  = cnt_if.expire && mode == MODE_ASLEEP;  // R3
  assign wake         = mode == MODE_ASLEEP && !master_clear_pin && (wdt_wake_evt || irq_wake);  // R11
  assign start_delay  = wake && crystal_mode;
  assign next_resume  = (wake && !crystal_mode) || (mode == MODE_STARTUP && delay_done && !master_clear_pin);

  // ==========================================================
  // Watchdog and shared prescaler
  assign cnt_if.clear      = (CLEAR_WATCHDOG_INSTR && mode == MODE_RUN) || sleep_exec;  // R7
  assign cnt_if.wdt_tick   = WDT_OSC_TICK;  // R1
  assign cnt_if.tmr0_tick  = TMR0_CLK_TICK;
  assign cnt_if.enable     = wdt_enabled;
  assign cnt_if.assign_wdt = timer_prescale_option[OPT_ASSIGN_BIT];  // R6
  assign cnt_if.ratio      = timer_prescale_option[OPT_RATIO_LSB +: 3];
  assign TMR0_INCREMENT    = cnt_if.tmr0_inc;

  prescale_counter #(
    .BASE_TICKS (WDT_BASE_TICKS)
  ) u_counter (
    .clk   (CLK),
    .rst_b (RST_B),
    .cnt   (cnt_if.counter)
  );

  startup_delay #(
    .CYCLES (OST_CYCLES)
  ) u_startup (
    .clk   (CLK),
    .rst_b (RST_B),
    .abort (master_clear_pin),
    .start (start_delay),
    .done  (delay_done)
  );

  // ==========================================================
  // Sleep state
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mode <= MODE_RUN;
    end else begin
      unique case (mode)
        MODE_RUN: begin
          if (sleep_exec) begin
            mode <= MODE_ASLEEP;  // R9
          end
        end
        MODE_ASLEEP: begin
          if (master_clear_pin) begin
            mode <= MODE_RUN;  // R11
          end else if (start_delay) begin
            mode <= MODE_STARTUP;  // R19
          end else if (wake) begin
            mode <= MODE_RUN;  // R3
          end
        end
        MODE_STARTUP: begin
          if (master_clear_pin || delay_done) begin
            mode <= MODE_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Status flags; a sleep in the same cycle as an expiry wins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;  // R12
    end else begin
      if (sleep_exec) begin
        timeout_flag   <= 1'b1;  // R9
        powerdown_flag <= 1'b0;  // R12
      end else if (cnt_if.expire) begin
        timeout_flag <= 1'b0;  // R4
      end
    end
  end

  // ==========================================================
  // Core-facing strobes
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      DEVICE_RESET      <= 1'b0;
      WATCHDOG_RESET    <= 1'b0;
      RESUME            <= 1'b0;
      VECTOR_AFTER_NEXT <= 1'b0;
    end else begin
      DEVICE_RESET      <= wdt_reset_evt || master_clear_pin;  // R2
      WATCHDOG_RESET    <= wdt_reset_evt;
      RESUME            <= next_resume;  // R18
      // Core runs the next instruction, then pushes only its return address
      VECTOR_AFTER_NEXT <= next_resume && GLOBAL_IRQ_ENABLE;  // R16 R20
    end
  end

  assign PREFETCH_NEXT  = SLEEP_INSTR && mode == MODE_RUN;  // R14
  assign CORE_HALT      = mode != MODE_RUN;
  assign IO_HOLD        = mode != MODE_RUN;  // R10
  assign OSC_DRIVER_ON  = mode != MODE_ASLEEP;  // R9
  assign VECTOR_ADDR    = IRQ_VECTOR;
  assign TIMEOUT_FLAG   = timeout_flag;
  assign POWERDOWN_FLAG = powerdown_flag;

  // ==========================================================
  // AXI4-Lite slave: address and data taken together
  assign wr_take = AWVALID && WVALID && !BVALID;
  assign AWREADY = wr_take;
  assign WREADY  = wr_take;
  assign rd_take = ARVALID && !RVALID;
  assign ARREADY = rd_take;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      config_word <= CONFIG_RESET;
    end else if (wr_take && AWADDR == ADDR_CONFIG && WSTRB[0]) begin
      config_word <= WDATA[7:0];
    end
  end

  // Option falls back to its reset value on any device reset
  always_ff @(posedge CLK) begin
    if (!RST_B || wdt_reset_evt || master_clear_pin) begin
      timer_prescale_option <= OPTION_RESET;
    end else if (wr_take && AWADDR == ADDR_OPTION && WSTRB[0]) begin
      timer_prescale_option <= WDATA[7:0];  // R6
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      BVALID <= 1'b0;
      BRESP  <= RESP_OKAY;
    end else if (wr_take) begin
      BVALID <= 1'b1;
      BRESP  <= (AWADDR == ADDR_CONFIG || AWADDR == ADDR_OPTION || AWADDR == ADDR_STATUS)
                ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RVALID <= 1'b0;
      RRESP  <= RESP_OKAY;
      RDATA  <= 32'h00000000;
    end else if (rd_take) begin
      RVALID <= 1'b1;
      RRESP  <= RESP_OKAY;
      RDATA  <= 32'h00000000;
      unique case (ARADDR)
        ADDR_CONFIG: RDATA[7:0] <= config_word;
        ADDR_OPTION: RDATA[7:0] <= timer_prescale_option;
        ADDR_STATUS: begin
          RDATA[ST_ASLEEP_BIT]  <= mode == MODE_ASLEEP;
          RDATA[ST_STARTUP_BIT] <= mode == MODE_STARTUP;
          RDATA[ST_PD_BIT]      <= powerdown_flag;
          RDATA[ST_TO_BIT]      <= timeout_flag;
        end
        default: RRESP <= RESP_SLVERR;
      endcase
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_sleep_entry: assert property (  // R9
    @(posedge CLK) disable iff (!RST_B)
    sleep_exec |=> mode == MODE_ASLEEP && timeout_flag && !powerdown_flag && !OSC_DRIVER_ON)
    else $error("sleep entry did not set flags and stop oscillator");

  a_sleep_noop: assert property (  // R17
    @(posedge CLK) disable iff (!RST_B)
    sleep_nop && !cnt_if.expire && !master_clear_pin |=>
      mode == MODE_RUN && $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("sleep with pending interrupt was not a no-op");

  a_run_expiry: assert property (  // R2
    @(posedge CLK) disable iff (!RST_B)
    cnt_if.expire && mode == MODE_RUN |=> DEVICE_RESET && WATCHDOG_RESET)
    else $error("expiry while running gave no reset");

  a_sleep_expiry: assert property (  // R3
    @(posedge CLK) disable iff (!RST_B)
    wdt_wake_evt && !master_clear_pin |=> mode != MODE_ASLEEP && !WATCHDOG_RESET && !DEVICE_RESET)
    else $error("expiry while asleep did not wake cleanly");

  a_timeout_clear: assert property (  // R4
    @(posedge CLK) disable iff (!RST_B)
    cnt_if.expire && !sleep_exec |=> !timeout_flag)
    else $error("timeout flag not cleared on expiry");

  a_fuse_off: assert property (  // R5
    @(posedge CLK) disable iff (!RST_B)
    !wdt_enabled ##1 !wdt_enabled |-> !cnt_if.expire)
    else $error("watchdog expired while disabled");

  a_pins_held: assert property (  // R10
    @(posedge CLK) disable iff (!RST_B)
    mode == MODE_ASLEEP |-> IO_HOLD && CORE_HALT)
    else $error("pins not held during sleep");

  a_pin_reset: assert property (  // R11
    @(posedge CLK) disable iff (!RST_B)
    mode == MODE_ASLEEP && master_clear_pin |=> DEVICE_RESET && mode == MODE_RUN && !RESUME)
    else $error("reset pin did not reset from sleep");

  a_powerdown_hold: assert property (  // R12
    @(posedge CLK) disable iff (!RST_B)
    !powerdown_flag |=> !powerdown_flag)
    else $error("powerdown flag set outside power-up");

  a_irq_wake: assert property (  // R15
    @(posedge CLK) disable iff (!RST_B)
    mode == MODE_ASLEEP && irq_wake && !master_clear_pin && !crystal_mode |=> RESUME ##1 mode == MODE_RUN)
    else $error("enabled interrupt did not wake");

  a_resume_vector: assert property (  // R16
    @(posedge CLK) disable iff (!RST_B)
    RESUME |-> VECTOR_AFTER_NEXT == $past(GLOBAL_IRQ_ENABLE))
    else $error("vector request does not follow global enable");
endmodule
`default_nettype wire

// ---- hdl/wdt_count_if.sv ----
// Link between the sleep controller and the shared prescale counter
`timescale 1ns/10ps
`default_nettype none
interface wdt_count_if;
  logic       clear;
  logic       wdt_tick;
  logic       tmr0_tick;
  logic       enable;
  logic       assign_wdt;
  logic [2:0] ratio;
  logic       expire;
  logic       tmr0_inc;
  modport ctrl    (output clear, wdt_tick, tmr0_tick, enable, assign_wdt, ratio,
                   input expire, tmr0_inc);
  modport counter (input clear, wdt_tick, tmr0_tick, enable, assign_wdt, ratio,
                   output expire, tmr0_inc);
endinterface
`default_nettype wire

// ---- hdl/wdt_pkg.sv ----
// Shared constants for the watchdog, sleep and wake-up block
package wdt_pkg;
  // ==========================================================
  // Register map (byte addresses, AXI4-Lite)
  localparam logic [11:0] ADDR_CONFIG  = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] OPTION_INDEX = 12'h081;
  localparam logic [11:0] ADDR_OPTION  = OPTION_INDEX << 2;
  // ==========================================================
  // Fields and reset values
  localparam int          CFG_WDT_EN_BIT = 2;
  localparam int          CFG_OSC_LSB    = 0;
  localparam logic [1:0]  OSC_LP         = 2'h0;
  localparam logic [1:0]  OSC_XT         = 2'h1;
  localparam logic [1:0]  OSC_HS         = 2'h2;
  localparam logic [1:0]  OSC_RC         = 2'h3;
  localparam logic [7:0]  CONFIG_RESET   = 8'h07;
  localparam int          OPT_ASSIGN_BIT = 3;
  localparam int          OPT_RATIO_LSB  = 0;
  localparam logic [7:0]  OPTION_RESET   = 8'hFF;
  localparam int          ST_ASLEEP_BIT  = 0;
  localparam int          ST_STARTUP_BIT = 1;
  localparam int          ST_PD_BIT      = 3;
  localparam int          ST_TO_BIT      = 4;
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // ==========================================================
  // Timing
  localparam int OSC_PERIOD_NS = 20;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OST_PERIODS   = 1024;
  localparam int OST_CYCLES    = (OST_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_BASE_TICKS_DEF = 256;
endpackage

// ---- testbench/core_model.sv ----
// Processor core model: watchdog RC tick, sleep and clear-watchdog issue
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic clk,
  input  wire logic tick_en,
  output logic      osc_tick,
  output logic      sleep_instr,
  output logic      clear_instr
);
  logic [1:0] div;
  initial begin
    osc_tick = 1'b0;
    sleep_instr = 1'b0;
    clear_instr = 1'b0;
    div = 2'h0;
  end
  // ==========================================================
  // Free-running RC tick, phase unrelated to the instructions
  always @(posedge clk) begin
    div <= div + 2'h1;
    osc_tick <= tick_en && (div == 2'h3);
  end
  // ==========================================================
  // Instruction pulses, one cycle each
  task automatic clear_op;
    @(posedge clk);
    clear_instr <= 1'b1;
    @(posedge clk);
    clear_instr <= 1'b0;
  endtask
  task automatic sleep_op(input logic clr_first);
    if (clr_first) clear_op();
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/watchdog_sleep_wakeup_bench.sv ----
// Self-checking bench for the watchdog, sleep and wake-up block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module watchdog_sleep_wakeup_bench;
  import wdt_pkg::*;
  localparam int BASE = 4;
  logic             clk, rst_b, awvalid, wvalid, bready, arvalid, rready, global_irq_enable, tick_en;
  logic [11:0]      awaddr, araddr;
  logic [31:0]      wdata;
  logic [7:0]       irq_fl, irq_en;
  logic             rst_seen, pf_seen, master_clear_pin_b, t0_tick;
  logic [3:0]       wstrb;
  int               n_mismatch, checks, n_t0;
  wire logic        awready, wready, bvalid, arready, rvalid, tmr0_inc, dev_rst, wdt_rst;
  wire logic        prefetch, halt, resume, vec_next, io_hold, osc_on, to_flag, pd_flag;
  wire logic        osc_tick, sleep_i, clear_i;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [12:0] vec_addr;

  watchdog_sleep_wakeup #(.WDT_BASE_TICKS(BASE), .SLEEP_WAKE_MASK(8'h7F)) dut (
    .CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .WDT_OSC_TICK(osc_tick), .TMR0_CLK_TICK(t0_tick), .TMR0_INCREMENT(tmr0_inc),
    .CLEAR_WATCHDOG_INSTR(clear_i), .SLEEP_INSTR(sleep_i), .GLOBAL_IRQ_ENABLE(global_irq_enable),
    .IRQ_FLAGS(irq_fl), .IRQ_ENABLES(irq_en), .MASTER_CLEAR_PIN_B(master_clear_pin_b),
    .DEVICE_RESET(dev_rst), .WATCHDOG_RESET(wdt_rst), .PREFETCH_NEXT(prefetch),
    .CORE_HALT(halt), .RESUME(resume), .VECTOR_AFTER_NEXT(vec_next),
    .VECTOR_ADDR(vec_addr), .IO_HOLD(io_hold), .OSC_DRIVER_ON(osc_on),
    .TIMEOUT_FLAG(to_flag), .POWERDOWN_FLAG(pd_flag));
  core_model core (.clk(clk), .tick_en(tick_en), .osc_tick(osc_tick),
    .sleep_instr(sleep_i), .clear_instr(clear_i));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (dev_rst === 1'b1) rst_seen = 1'b1;
    if (prefetch === 1'b1) pf_seen = 1'b1;
    if (tmr0_inc === 1'b1) n_t0++;
  end
  // ==========================================================
  // Bus tasks; ready and valid looked at once settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd(ADDR_CONFIG, d, r);
    `CHK("config", CONFIG_RESET, d[7:0])
    // Low byte lane off: the write must leave the register alone
    wstrb <= 4'hE;
    wr(ADDR_OPTION, 32'h0);
    wstrb <= 4'hF;
    rd(ADDR_OPTION, d, r);
    `CHK("option", OPTION_RESET, d[7:0])
    rd(ADDR_STATUS, d, r);
    `CHK("status", 8'h18, d[7:0])
    rd(12'h100, d, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    $display("test reset done");
  endtask
  task automatic t_noop;
    irq_en <= 8'h01;
    irq_fl <= 8'h01;
    core.sleep_op(1'b0);
    @(negedge clk);
    `CHK("halt", 1'b0, halt)
    `CHK("pd flag", 1'b1, pd_flag)
    `CHK("to flag", 1'b1, to_flag)
    @(posedge clk);
    irq_fl <= 8'h00;
    $display("test noop done");
  endtask
  task automatic t_irq_wake(input logic [1:0] m);
    int n;
    wr(ADDR_CONFIG, {29'h0, 1'b1, m});
    global_irq_enable <= m[0];
    irq_en <= 8'h81;
    pf_seen = 1'b0;
    core.sleep_op(1'b1);
    @(negedge clk);
    `CHK("halt", 1'b1, halt)
    `CHK("osc drv", 1'b0, osc_on)
    `CHK("to flag", 1'b1, to_flag)
    `CHK("pd flag", 1'b0, pd_flag)
    `CHK("io hold", 1'b1, io_hold)
    `CHK("prefetch", 1'b1, pf_seen)
    @(posedge clk);
    irq_fl <= 8'h02;
    repeat (4) @(negedge clk);
    `CHK("masked wake", 1'b1, halt)
    @(posedge clk);
    irq_fl <= 8'h80;
    repeat (4) @(negedge clk);
    `CHK("clocked src", 1'b1, halt)
    @(posedge clk);
    irq_fl <= 8'h81;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (resume !== 1'b1 && n < 2000);
    `CHK("wake delay", (m == OSC_RC) ? 2 : OST_CYCLES + 3, n)
    `CHK("vector", m[0], vec_next)
    `CHK("vector addr", IRQ_VECTOR, vec_addr)
    @(posedge clk);
    irq_fl <= 8'h00;
    irq_en <= 8'h00;
    @(negedge clk);
    `CHK("running", 1'b0, halt)
    $display("test irq wake %0d done", m);
  endtask
  task automatic t_wdt_wake;
    int n, k;
    wr(ADDR_CONFIG, 32'h7);
    wr(ADDR_OPTION, 32'h0);
    core.clear_op();
    rst_seen = 1'b0;
    tick_en <= 1'b1;
    n = 0;
    // Stop one tick short so only the sleep's own clear saves it
    do begin
      @(negedge clk);
      if (osc_tick) n++;
    end while (n < BASE - 1);
    core.sleep_op(1'b0);
    n = 0;
    k = 0;
    do begin
      @(negedge clk);
      if (osc_tick) n++;
      k++;
    end while (resume !== 1'b1 && k < 500);
    `CHK("sleep ticks", BASE, n)
    `CHK("no reset", 1'b0, rst_seen)
    `CHK("to flag", 1'b0, to_flag)
    @(posedge clk);
    tick_en <= 1'b0;
    $display("test watchdog wake done");
  endtask
  task automatic t_clear_fuse;
    // Six ticks per clear: base wraps once, so a stale prescaler would expire
    wr(ADDR_OPTION, 32'h9);
    rst_seen = 1'b0;
    tick_en <= 1'b1;
    repeat (10) begin
      repeat (22) @(posedge clk);
      core.clear_op();
    end
    `CHK("cleared", 1'b0, rst_seen)
    wr(ADDR_CONFIG, 32'h3);
    repeat (200) @(posedge clk);
    `CHK("fuse off", 1'b0, rst_seen)
    tick_en <= 1'b0;
    wr(ADDR_CONFIG, 32'h7);
    $display("test clear and fuse done");
  endtask
  task automatic t_expire(input logic [3:0] op);
    int n, k;
    wr(ADDR_OPTION, {28'h0, op});
    core.clear_op();
    tick_en <= 1'b1;
    n = 0;
    k = 0;
    do begin
      @(negedge clk);
      if (osc_tick) n++;
      k++;
    end while (dev_rst !== 1'b1 && k < 500);
    `CHK("expiry ticks", op[3] ? BASE << op[2:0] : BASE, n)
    `CHK("wdt cause", 1'b1, wdt_rst)
    @(posedge clk);
    tick_en <= 1'b0;
    @(negedge clk);
    `CHK("to flag", 1'b0, to_flag)
    $display("test expire %0h done", op);
  endtask
  task automatic t_pin_reset;
    logic [31:0] d;
    logic [1:0]  r;
    wr(ADDR_OPTION, 32'h0);
    core.sleep_op(1'b1);
    @(posedge clk);
    master_clear_pin_b <= 1'b0;
    @(posedge clk);
    master_clear_pin_b <= 1'b1;
    @(negedge clk);
    `CHK("pin reset", 1'b1, dev_rst)
    `CHK("pin no wake", 1'b0, resume)
    `CHK("pin halt", 1'b0, halt)
    `CHK("pin pd", 1'b0, pd_flag)
    rd(ADDR_OPTION, d, r);
    `CHK("pin option", OPTION_RESET, d[7:0])
    $display("test pin reset done");
  endtask
  task automatic t_tmr0;
    wr(ADDR_OPTION, 32'h8);
    n_t0 = 0;
    t0_tick <= 1'b1;
    repeat (8) @(posedge clk);
    t0_tick <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("t0 direct", 8, n_t0)
    wr(ADDR_OPTION, 32'h0);
    n_t0 = 0;
    t0_tick <= 1'b1;
    repeat (8) @(posedge clk);
    t0_tick <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("t0 scaled", 1'b1, n_t0 < 8)
    $display("test timer0 done");
  endtask
  // ==========================================================
  // Verdict and main sequence
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #800000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, global_irq_enable, tick_en} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    irq_fl = 8'h00;
    irq_en = 8'h00;
    master_clear_pin_b = 1'b1;
    t0_tick = 1'b0;
    wstrb = 4'hF;
    rst_seen = 1'b0;
    pf_seen = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_noop();
    for (int m = 0; m < 4; m++) t_irq_wake(m[1:0]);
    t_wdt_wake();
    t_clear_fuse();
    t_expire(4'h0);
    t_expire(4'h8);
    t_expire(4'hA);
    t_expire(4'h5);
    t_pin_reset();
    t_tmr0();
    print_verdict();
  end
endmodule
`default_nettype wire
